// ### rtl/stcb_counter_bank.sv
`default_nettype none
// Notes on behaviour
// [R1] without management option every access answers error
// [R2] counter width is 32 or 64 bits
// [R3] low word read captures upper half
// [R4] upper read returns the captured half
// [R5] upper read of other counter errors
// [R6] writes change nothing and answer error
// [R7] option decides whether reset clears counters
// [R8] reads never clear; counters wrap to zero
// [R9] software reads often enough to catch wraps
// [R10] one toggle bit per counter 4..43
// [R11] every level change is one increment
// [R12] toggle detection runs on the stats clock
// [R13] memory walked round robin, pending ones incremented
// [R14] each visit is one read, one write-back
// [R15] counters 0..3 fed by internal per-cycle sources
// [R16] two frame-size groups of seven, one-hot
// [R17] one slot per frame-size group, 32 slots
// [R18] decode toggles each bit once per frame
// [R19] stats clock fast enough for MAC rate
// [R20] sticky pending flag per toggle bit
module stcb_counter_bank #(
   parameter int CNT_W     = stcb_pkg::CNT_W_DEF,
   parameter bit MGMT_EN   = 1'b1,
   parameter bit CLR_ON_RST = 1'b0,
   parameter bit GIGABIT   = 1'b0
) (
   input  wire logic                             mclk_i,
   input  wire logic                             resetn_i,
   input  wire logic [stcb_pkg::NUM_LO-1:0]      inc_toggle_i,
   input  wire logic [stcb_pkg::NUM_HI-1:0]      hi_inc_i,
   input  wire stcb_pkg::stcb_req_t              req_i,
   output stcb_pkg::stcb_rsp_t                   rsp_o
);
   localparam int WORD_W = stcb_pkg::WORD_W;
   // a 32-bit build keeps a one-bit dummy capture so the casts stay legal
   localparam int HI_W   = (CNT_W > WORD_W) ? CNT_W - WORD_W : 1;
   localparam int CIDX_W = 6;
   localparam int AW     = stcb_pkg::HI_ACC_W;

   // elaboration checks
   if (CNT_W != 32 && CNT_W != 64) begin : g_bad_width
      $error("counter width must be 32 or 64"); // [R2]
   end
   if (GIGABIT && stcb_pkg::ROUND_CYC > stcb_pkg::FRAME_CYC) begin : g_slow_clk
      $error("stats clock too slow for gigabit operation"); // [R19]
   end
   if (stcb_pkg::NUM_SLOT > 32) begin : g_bad_slots
      $error("slot counter too narrow for the round");
   end
   if (stcb_pkg::ADDR_W < CIDX_W + 1) begin : g_bad_addr
      $error("address too narrow for the counter map");
   end


   typedef enum logic {PH_READ, PH_WRITE} stcb_phase_t;

   logic [CNT_W-1:0]               mem [stcb_pkg::NUM_CNT];
   logic [stcb_pkg::NUM_LO-1:0]    sync1_ff;
   logic [stcb_pkg::NUM_LO-1:0]    sync2_ff;
   logic [stcb_pkg::NUM_LO-1:0]    last_ff;
   logic [stcb_pkg::NUM_LO-1:0]    pend_ff;
   logic [stcb_pkg::NUM_LO-1:0]    toggled;
   logic [stcb_pkg::NUM_LO-1:0]    clr_pend;
   logic [AW-1:0]                  acc_ff [stcb_pkg::NUM_HI];
   logic [stcb_pkg::NUM_HI-1:0]    clr_acc;
   stcb_phase_t                    phase_ff;
   logic [4:0]                     slot_ff;
   logic [CIDX_W-1:0]              cur_idx;
   logic [CIDX_W-1:0]              idx_ff;
   logic [AW-1:0]                  cur_delta;
   logic [AW-1:0]                  delta_ff;
   logic [CNT_W-1:0]               rdata_ff;
   logic [HI_W-1:0]                hold_ff;
   logic [CIDX_W-1:0]              held_idx_ff;
   logic                           held_ok_ff;
   stcb_pkg::stcb_rsp_t            rsp_ff;

   // toggle synchronisers and edge detection, one per low-rate bit
   for (genvar b = 0; b < stcb_pkg::NUM_LO; b++) begin : g_lo
      always_ff @(posedge mclk_i) begin
         if (!resetn_i) begin
            // track the pin through reset: a toggled level left over
            // from before reset must not look like a fresh edge
            sync1_ff[b] <= inc_toggle_i[b];
            sync2_ff[b] <= sync1_ff[b];
            last_ff[b]  <= sync2_ff[b];
         end else begin
            sync1_ff[b] <= inc_toggle_i[b]; // [R12]
            sync2_ff[b] <= sync1_ff[b];
            last_ff[b]  <= sync2_ff[b];
         end
      end
      // any level change counts once, either direction
      assign toggled[b] = sync2_ff[b] ^ last_ff[b]; // [R11] [R10]

      // a toggle landing on the clearing visit survives
      always_ff @(posedge mclk_i) begin
         if (!resetn_i) begin
            pend_ff[b] <= 1'b0;
         end else begin
            pend_ff[b] <= toggled[b] | (pend_ff[b] & ~clr_pend[b]); // [R20]
         end
      end
   end

   // high-rate sources accumulate between visits
   for (genvar h = 0; h < stcb_pkg::NUM_HI; h++) begin : g_hi
      always_ff @(posedge mclk_i) begin
         if (!resetn_i) begin
            acc_ff[h] <= '0;
         end else if (clr_acc[h]) begin
            acc_ff[h] <= AW'(hi_inc_i[h]); // [R15]
         end else begin
            acc_ff[h] <= acc_ff[h] + AW'(hi_inc_i[h]); // [R15]
         end
      end
   end

   // slot to counter map; each frame-size group takes one slot
   function automatic logic [CIDX_W-1:0] slot_base(input logic [4:0] s);
      int unsigned si;
      si = s;
      if (si > stcb_pkg::TXFS_BASE - (stcb_pkg::FS_GROUP - 1)) begin
         si = si + 2 * (stcb_pkg::FS_GROUP - 1);
      end else if (si > stcb_pkg::RXFS_BASE) begin
         si = si + (stcb_pkg::FS_GROUP - 1);
      end
      return CIDX_W'(si);
   endfunction : slot_base

   // pick the one pending member of a frame-size group
   function automatic logic [CIDX_W-1:0] pick_fs(input logic [CIDX_W-1:0] base,
                                                input logic [stcb_pkg::NUM_LO-1:0] p);
      logic [CIDX_W-1:0] sel;
      sel = base;
      for (int k = stcb_pkg::FS_GROUP - 1; k >= 0; k--) begin
         if (p[int'(base) + k - stcb_pkg::LO_FIRST]) begin
            sel = base + CIDX_W'(k);
         end
      end
      return sel;
   endfunction : pick_fs

   always_comb begin
      logic [CIDX_W-1:0] base;
      base      = slot_base(slot_ff);
      cur_idx   = base;
      cur_delta = '0;
      clr_pend  = '0;
      clr_acc   = '0;
      if (base == CIDX_W'(stcb_pkg::RXFS_BASE) || base == CIDX_W'(stcb_pkg::TXFS_BASE)) begin
         cur_idx = pick_fs(base, pend_ff); // [R16] [R17]
      end
      if (phase_ff == PH_READ) begin
         if (int'(cur_idx) < stcb_pkg::NUM_HI) begin
            cur_delta                 = acc_ff[cur_idx[1:0]];
            clr_acc[cur_idx[1:0]]     = 1'b1;
         end else begin
            cur_delta = AW'(pend_ff[int'(cur_idx) - stcb_pkg::LO_FIRST]);
            clr_pend[int'(cur_idx) - stcb_pkg::LO_FIRST] = 1'b1; // [R13]
         end
      end
   end

   // two accesses per visit: read phase, then write-back phase
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         phase_ff <= PH_READ;
         slot_ff  <= '0;
         idx_ff   <= '0;
         delta_ff <= '0;
         rdata_ff <= '0;
      end else if (phase_ff == PH_READ) begin
         phase_ff <= PH_WRITE; // [R14]
         idx_ff   <= cur_idx;
         delta_ff <= cur_delta;
         rdata_ff <= mem[cur_idx];
      end else begin
         phase_ff <= PH_READ;
         slot_ff  <= (slot_ff == 5'(stcb_pkg::NUM_SLOT - 1)) ? '0 : slot_ff + 5'd1; // [R13]
      end
   end

   // plain add wraps to zero at full scale; sw reads never touch memory
   always_ff @(posedge mclk_i) begin
      if (!resetn_i && CLR_ON_RST) begin
         for (int i = 0; i < stcb_pkg::NUM_CNT; i++) begin
            mem[i] <= '0; // [R7]
         end
      end else if (resetn_i && phase_ff == PH_WRITE && delta_ff != '0) begin
         mem[idx_ff] <= rdata_ff + CNT_W'(delta_ff); // [R8] [R14]
      end
   end

   // software address decode, shared by the capture and the answer
   logic [CIDX_W-1:0] rd_cnt_idx;
   logic              rd_upper;
   logic              rd_mapped;
   logic              take_req;
   logic              take_low;
   logic              take_up;
   logic              pair_ok;

   always_comb begin
      if (CNT_W == 64) begin
         rd_cnt_idx = req_i.addr[CIDX_W:1];
         rd_upper   = req_i.addr[0];
      end else begin
         rd_cnt_idx = req_i.addr[CIDX_W-1:0];
         rd_upper   = 1'b0;
      end
      rd_mapped = int'(rd_cnt_idx) < stcb_pkg::NUM_CNT;
      if (CNT_W != 64 && req_i.addr[CIDX_W]) begin
         rd_mapped = 1'b0;
      end
      take_req = req_i.rd | req_i.wr;
      // rd and wr together count as a write, so nothing is captured
      take_low = MGMT_EN && req_i.rd && !req_i.wr && rd_mapped && !rd_upper;
      take_up  = MGMT_EN && req_i.rd && !req_i.wr && rd_mapped && rd_upper;
      pair_ok  = held_ok_ff && held_idx_ff == rd_cnt_idx;
   end

   // upper half frozen at the low read, so a carry between the two
   // reads cannot tear the value; an upper read leaves it in place
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         hold_ff     <= '0;
         held_idx_ff <= '0;
         held_ok_ff  <= 1'b0;
      end else if (take_low && CNT_W == 64) begin
         hold_ff     <= HI_W'(mem[rd_cnt_idx] >> WORD_W); // [R3]
         held_idx_ff <= rd_cnt_idx;
         held_ok_ff  <= 1'b1;
      end
   end

   // answer one cycle after the request; ack stands as long as the request
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.ack  <= take_req;
         rsp_ff.err  <= 1'b0;
         rsp_ff.data <= stcb_pkg::RESET_WORD;
         if (!MGMT_EN) begin
            rsp_ff.err <= take_req; // [R1]
         end else if (req_i.wr) begin
            rsp_ff.err <= 1'b1; // [R6]
         end else if (take_low) begin
            // live low word; pending flags are not yet in memory
            rsp_ff.data <= mem[rd_cnt_idx][WORD_W-1:0];
         end else if (take_up && pair_ok) begin
            rsp_ff.data <= WORD_W'(hold_ff); // [R4]
         end else if (take_up) begin
            rsp_ff.err <= 1'b1; // [R5]
         end else if (req_i.rd) begin
            // past the last counter: nothing to return
            rsp_ff.err <= 1'b1;
         end
      end
   end


   assign rsp_o = rsp_ff;
endmodule : stcb_counter_bank
`default_nettype wire

// ### pkg/stcb_pkg.sv
`default_nettype none
package stcb_pkg;
   localparam int NUM_CNT       = 44;
   localparam int NUM_HI        = 4;
   localparam int LO_FIRST      = 4;
   localparam int LO_LAST       = 43;
   localparam int NUM_LO        = LO_LAST - LO_FIRST + 1;
   localparam int FS_GROUP      = 7;
   localparam int RXFS_BASE     = 9;
   localparam int TXFS_BASE     = 25;
   localparam int NUM_SLOT      = NUM_CNT - 2 * (FS_GROUP - 1);
   localparam int ACC_PER_VISIT = 2;
   localparam int CNT_W_DEF     = 64;
   localparam int WORD_W        = 32;
   localparam int ADDR_W        = 7;
   localparam int MIN_FRAME_NS  = 584;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ROUND_CYC     = NUM_SLOT * ACC_PER_VISIT;
   localparam int FRAME_CYC     = MIN_FRAME_NS / CLK_PERIOD_NS;
   localparam int HI_ACC_W      = $clog2(ROUND_CYC + 1) + 1;
   localparam logic [WORD_W-1:0] RESET_WORD = 32'h0000_0000;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
   } stcb_req_t;

   typedef struct packed {
      logic              ack;
      logic              err;
      logic [WORD_W-1:0] data;
   } stcb_rsp_t;
endpackage : stcb_pkg
`default_nettype wire

// ### verification/stcb_counter_bank_properties.sv
`default_nettype none
module stcb_cb_props (
   input wire logic                        mclk_i,
   input wire logic                        resetn_i,
   input wire logic [stcb_pkg::NUM_LO-1:0] inc_toggle_i,
   input wire logic [stcb_pkg::NUM_HI-1:0] hi_inc_i,
   input wire stcb_pkg::stcb_req_t         req_i,
   input wire stcb_pkg::stcb_rsp_t         rsp_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic [5:0] lo_cnt_ff;
   logic       lo_vld_ff;
   wire logic  rd_only = req_i.rd && !req_i.wr;
   wire logic  in_rng  = req_i.addr[6:1] < 6'h2C;
   wire logic  lo_rd   = rd_only && !req_i.addr[0] && in_rng;
   wire logic  up_hit  = rd_only && req_i.addr[0] && lo_vld_ff && req_i.addr[6:1] == lo_cnt_ff;
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) lo_vld_ff <= 1'b0;
      else if (lo_rd) lo_vld_ff <= 1'b1;
   end
   always_ff @(posedge mclk_i) begin
      if (lo_rd) lo_cnt_ff <= req_i.addr[6:1];
   end
   sequence up_read;
      up_hit && in_rng;
   endsequence
   ack_follows_a: assert property ((req_i.rd || req_i.wr) |=> rsp_o.ack)
      else $error("request not answered");
   ack_idle_a: assert property (!(req_i.rd || req_i.wr) |=> !rsp_o.ack)
      else $error("answer without request");
   write_err_a: assert property (req_i.wr |=> rsp_o.err)
      else $error("write accepted");
   range_err_a: assert property (rd_only && !in_rng |=> rsp_o.err)
      else $error("read past last counter accepted");
   low_ok_a: assert property (lo_rd |=> !rsp_o.err)
      else $error("low word read refused");
   upper_ok_a: assert property (up_read |=> !rsp_o.err)
      else $error("paired upper read refused");
   upper_bad_a: assert property (rd_only && req_i.addr[0] && in_rng && !up_hit
      |=> rsp_o.err && rsp_o.data == 32'h0000_0000) else $error("unpaired upper read");
   upper_stable_a: assert property (up_read ##1 (up_hit && in_rng && $stable(req_i.addr))
      |=> rsp_o.data == $past(rsp_o.data)) else $error("captured half moved");
endmodule : stcb_cb_props
bind stcb_counter_bank stcb_cb_props u_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .inc_toggle_i(inc_toggle_i), .hi_inc_i(hi_inc_i), .req_i(req_i), .rsp_o(rsp_o));
`default_nettype wire

// ### verification/stcb_decode_model.sv
`default_nettype none
module stcb_decode_model (
   input  wire logic                        mclk_i,
   output var logic [stcb_pkg::NUM_LO-1:0]  toggle_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial toggle_o = '0;
   // at this slow clock a full round must pass, else two toggles merge
   task automatic bump(input int k);
      repeat (stcb_pkg::ROUND_CYC + 8) @(posedge mclk_i);
      toggle_o[k] <= ~toggle_o[k];
   endtask : bump
endmodule : stcb_decode_model
`default_nettype wire

// ### verification/stcb_counter_bank_tb.sv
`default_nettype none
module stcb_counter_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                         mclk   = 1'b0;
   logic                         resetn = 1'b0;
   logic [3:0]                   hi_inc = 4'h0;
   logic [39:0]                  tog;
   stcb_pkg::stcb_req_t          req    = '0;
   stcb_pkg::stcb_rsp_t          rsp;
   logic [32:0]                  r;
   int                           err_count   = 0;
   int                           checks_done = 0;
   always #20 mclk = ~mclk;
   stcb_decode_model partner (.mclk_i(mclk), .toggle_o(tog));
   stcb_counter_bank dut (.mclk_i(mclk), .resetn_i(resetn), .inc_toggle_i(tog),
      .hi_inc_i(hi_inc), .req_i(req), .rsp_o(rsp));
   function automatic void chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endfunction : chk
   task automatic access(input logic w, input logic [6:0] a);
      @(posedge mclk);
      req <= '{rd: ~w, wr: w, addr: a};
      @(posedge mclk);
      req <= '0;
      #1;
      chk("ack", 33'h0_0000_0001, {32'h0000_0000, rsp.ack});
      r = {rsp.err, rsp.data};
   endtask : access
   task automatic rd_cnt(input logic [5:0] c, input logic [63:0] v);
      access(1'b0, {c, 1'b0});
      chk("low word", {1'b0, v[31:0]}, r);
      access(1'b0, {c, 1'b1});
      chk("high word", {1'b0, v[63:32]}, r);
   endtask : rd_cnt
   task automatic t_count();
      @(posedge mclk);
      hi_inc <= 4'h1;
      repeat (3) @(posedge mclk);
      hi_inc <= 4'h0;
      partner.bump(0);
      partner.bump(0);
      partner.bump(5);
      partner.bump(39);
      repeat (2 * stcb_pkg::ROUND_CYC + 16) @(posedge mclk);
      rd_cnt(6'h00, 64'h3);
      rd_cnt(6'h04, 64'h2);
      rd_cnt(6'h09, 64'h1);
      rd_cnt(6'h2B, 64'h1);
      rd_cnt(6'h04, 64'h2);
      $display("test count done");
   endtask : t_count
   task automatic t_pair();
      access(1'b0, 7'h08);
      access(1'b0, 7'h13);
      chk("other upper", {1'b1, 32'h0000_0000}, r);
      @(posedge mclk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: 7'h09};
      repeat (2) @(posedge mclk);
      req <= '0;
      #1;
      chk("repeat upper", {1'b0, 32'h0000_0000}, {rsp.err, rsp.data});
      access(1'b1, 7'h08);
      chk("write err", 33'h1, {32'h0000_0000, r[32]});
      rd_cnt(6'h04, 64'h2);
      access(1'b0, 7'h58);
      chk("range err", 33'h1, {32'h0000_0000, r[32]});
      $display("test pair done");
   endtask : t_pair
   task automatic t_reset();
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      access(1'b0, 7'h09);
      chk("upper after reset", {1'b1, 32'h0000_0000}, r);
      repeat (stcb_pkg::ROUND_CYC + 8) @(posedge mclk);
      rd_cnt(6'h04, 64'h2);
      rd_cnt(6'h09, 64'h1);
      rd_cnt(6'h2B, 64'h1);
      $display("test reset done");
   endtask : t_reset
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      t_count();
      t_pair();
      t_reset();
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge mclk);
      err_count++;
      complete_run();
   end
endmodule : stcb_counter_bank_tb
`default_nettype wire
